/* hdl/brr_pkg.sv */
// Shared constants and types for branch resolve and register rotation.
// Assumes a 64-bit address space with 16-byte instruction bundles.
package brr_pkg;
  // ---------------------------------------------------------------
  // Address and displacement layout
  // ---------------------------------------------------------------
  localparam int          ADDR_W       = 64;
  localparam int          BUNDLE_SHIFT = 4;
  localparam int          DISP_S_W     = 21;
  localparam int          DISP_L_W     = 60;
  localparam logic [63:0] BUNDLE_BYTES = 64'h0000_0000_0000_0010;
  // ---------------------------------------------------------------
  // Rotating regions
  // ---------------------------------------------------------------
  localparam logic [6:0]  GR_ROT_BASE  = 7'h20;
  localparam logic [6:0]  GR_ROT_MAX   = 7'h60;
  localparam logic [6:0]  FR_ROT_BASE  = 7'h20;
  localparam logic [6:0]  FR_ROT_SIZE  = 7'h60;
  localparam logic [5:0]  PR_ROT_BASE  = 6'h10;
  localparam logic [5:0]  PR_ROT_SIZE  = 6'h30;
  localparam logic [2:0]  SOR_GRAIN    = 3'h0;
  localparam logic [5:0]  PR_ALWAYS_ON = 6'h00;
  localparam logic [1:0]  LOOP_SLOT    = 2'h2;
  // ---------------------------------------------------------------
  // Operation kinds and target modes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    K_COND      = 4'h0,
    K_CALL      = 4'h1,
    K_RET       = 4'h2,
    K_CLOOP     = 4'h3,
    K_CTOP      = 4'h4,
    K_WTOP      = 4'h5,
    K_CLRRRB    = 4'h6,
    K_CLRRRB_PR = 4'h7,
    K_ALLOC     = 4'h8
  } brr_kind_type;
  typedef enum logic [1:0] {
    M_IPREL    = 2'h0,
    M_LONG     = 2'h1,
    M_INDIRECT = 2'h2
  } brr_mode_type;
endpackage

/* hdl/brr_target.sv */
// Branch target adder for the three target modes.
// Assumes displacements already extracted by decode, in bundle units.
`timescale 1ns/1ps
module brr_target (
  input  wire logic [1:0]                   mode_i,
  input  wire logic [brr_pkg::ADDR_W-1:0]   ip_i,
  input  wire logic [brr_pkg::DISP_S_W-1:0] disp21_i,
  input  wire logic [brr_pkg::DISP_L_W-1:0] disp60_i,
  input  wire logic [brr_pkg::ADDR_W-1:0]   breg_i,
  output logic      [brr_pkg::ADDR_W-1:0]   target_o
);
  localparam int SEXT_W = brr_pkg::ADDR_W - brr_pkg::DISP_S_W - brr_pkg::BUNDLE_SHIFT;
  logic [brr_pkg::ADDR_W-1:0] short_off;
  logic [brr_pkg::ADDR_W-1:0] long_off;
  // ---------------------------------------------------------------
  // Offsets scaled to bytes; low bits forced zero keep bundle alignment
  // ---------------------------------------------------------------
  assign short_off = {{SEXT_W{disp21_i[brr_pkg::DISP_S_W-1]}}, disp21_i, {brr_pkg::BUNDLE_SHIFT{1'b0}}};
  assign long_off  = {disp60_i, {brr_pkg::BUNDLE_SHIFT{1'b0}}};
  // Mode select; unknown code falls back to the bundle itself
  always_comb begin
    unique case (brr_pkg::brr_mode_type'(mode_i))
      brr_pkg::M_IPREL:    target_o = ip_i + short_off;
      brr_pkg::M_LONG:     target_o = ip_i + long_off;
      brr_pkg::M_INDIRECT: target_o = {breg_i[brr_pkg::ADDR_W-1:brr_pkg::BUNDLE_SHIFT],
                                       {brr_pkg::BUNDLE_SHIFT{1'b0}}};
      default:             target_o = ip_i;
    endcase
  end
endmodule // brr_target

/* hdl/brr_rename.sv */
// Logical to physical register renamer for one rotating region.
// Assumes rrb_i is always below size_i; size zero disables rotation.
`timescale 1ns/1ps
module brr_rename #(
  parameter int             W    = 7,
  parameter logic [W-1:0]   BASE = '0
) (
  input  wire logic [W-1:0] num_i,
  input  wire logic [W-1:0] size_i,
  input  wire logic [W-1:0] rrb_i,
  output logic      [W-1:0] phys_o
);
  logic [W:0] off;
  logic [W:0] sum;
  // ---------------------------------------------------------------
  // Offset into region plus base, wrapped modulo region size
  // ---------------------------------------------------------------
  always_comb begin
    off = {1'b0, num_i} - {1'b0, BASE};
    sum = {1'b0, off[W-1:0]} + {1'b0, rrb_i};
    if (sum >= {1'b0, size_i}) begin
      sum = sum - {1'b0, size_i};
    end
    if ((num_i >= BASE) && (off < {1'b0, size_i})) begin
      phys_o = BASE + sum[W-1:0];
    end else begin
      phys_o = num_i;
    end
  end
endmodule // brr_rename

/* hdl/brr_top.sv */
// Branch resolution and rotating-register renaming, one cycle per op.
// Assumes decode presents one op per cycle with predicate value read.
`timescale 1ns/1ps
module brr_top #(
  parameter int LC_W = 64,
  parameter int EC_W = 6
) (
  input  wire logic                          MCLK_I,
  input  wire logic                          RESET_I,
  input  wire logic                          BR_VALID_I,
  input  wire logic [3:0]                    BR_KIND_I,
  input  wire logic [1:0]                    BR_MODE_I,
  input  wire logic [1:0]                    BR_SLOT_I,
  input  wire logic [brr_pkg::ADDR_W-1:0]    BUNDLE_IP_I,
  input  wire logic [brr_pkg::DISP_S_W-1:0]  DISP21_I,
  input  wire logic [brr_pkg::DISP_L_W-1:0]  DISP60_I,
  input  wire logic [brr_pkg::ADDR_W-1:0]    BREG_TARGET_I,
  input  wire logic [5:0]                    QP_NUM_I,
  input  wire logic                          QP_VALUE_I,
  input  wire logic [6:0]                    ALLOC_SOR_I,
  input  wire logic                          LC_WR_I,
  input  wire logic [LC_W-1:0]               LC_WDATA_I,
  input  wire logic                          EC_WR_I,
  input  wire logic [EC_W-1:0]               EC_WDATA_I,
  input  wire logic [6:0]                    GR_NUM_I,
  input  wire logic [6:0]                    FR_NUM_I,
  input  wire logic [5:0]                    PR_NUM_I,
  output logic                               TAKEN_O,
  output logic [brr_pkg::ADDR_W-1:0]         TARGET_O,
  output logic                               ILLEGAL_OP_O,
  output logic                               LINK_WE_O,
  output logic [brr_pkg::ADDR_W-1:0]         LINK_DATA_O,
  output logic                               STACK_CALL_O,
  output logic                               STACK_RET_O,
  output logic                               PR63_WE_O,
  output logic                               PR63_VALUE_O,
  output logic [LC_W-1:0]                    LOOP_COUNT_O,
  output logic [EC_W-1:0]                    EPILOG_COUNT_O,
  output logic [6:0]                         RRB_GR_O,
  output logic [6:0]                         RRB_FR_O,
  output logic [5:0]                         RRB_PR_O,
  output logic [6:0]                         ROT_SIZE_GR_O,
  output logic [6:0]                         GR_PHYS_O,
  output logic [6:0]                         FR_PHYS_O,
  output logic [5:0]                         PR_PHYS_O
);
  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  brr_pkg::brr_kind_type      kind;
  logic [1:0]                 mode_eff;
  logic                       qp;
  logic                       is_loop;
  logic                       slot_ok;
  logic                       rotate;
  logic [brr_pkg::ADDR_W-1:0] tgt;
  logic [6:0]                 gr_phys;
  logic [6:0]                 fr_phys;
  logic [5:0]                 pr_phys;

  assign kind    = brr_pkg::brr_kind_type'(BR_KIND_I);
  assign qp      = (QP_NUM_I == brr_pkg::PR_ALWAYS_ON) ? 1'b1 : QP_VALUE_I;
  assign is_loop = (kind == brr_pkg::K_CLOOP) || (kind == brr_pkg::K_CTOP) || (kind == brr_pkg::K_WTOP);
  assign slot_ok = (BR_SLOT_I == brr_pkg::LOOP_SLOT);
  // Returns are always indirect, loops always IP-relative
  assign mode_eff = (kind == brr_pkg::K_RET) ? brr_pkg::M_INDIRECT :
                    is_loop ? brr_pkg::M_IPREL : BR_MODE_I;

  brr_target u_target (
    .mode_i   (mode_eff),
    .ip_i     (BUNDLE_IP_I),
    .disp21_i (DISP21_I),
    .disp60_i (DISP60_I),
    .breg_i   (BREG_TARGET_I),
    .target_o (tgt)
  );

  // ---------------------------------------------------------------
  // Architectural and output state
  // ---------------------------------------------------------------
  logic                       taken_q, taken_d;
  logic [brr_pkg::ADDR_W-1:0] target_q, target_d;
  logic                       illegal_q, illegal_d;
  logic                       link_we_q, link_we_d;
  logic [brr_pkg::ADDR_W-1:0] link_q, link_d;
  logic                       call_q, call_d;
  logic                       ret_q, ret_d;
  logic                       pr63_we_q, pr63_we_d;
  logic                       pr63_q, pr63_d;
  logic [LC_W-1:0]            lc_q, lc_d;
  logic [EC_W-1:0]            ec_q, ec_d;
  logic [6:0]                 rrb_gr_q, rrb_gr_d;
  logic [6:0]                 rrb_fr_q, rrb_fr_d;
  logic [5:0]                 rrb_pr_q, rrb_pr_d;
  logic [6:0]                 sor_q, sor_d;
  logic [6:0]                 gr_phys_q;
  logic [6:0]                 fr_phys_q;
  logic [5:0]                 pr_phys_q;

  // Next-state: one op per cycle, op effects win over software writes
  always_comb begin
    taken_d   = 1'b0;
    illegal_d = 1'b0;
    link_we_d = 1'b0;
    call_d    = 1'b0;
    ret_d     = 1'b0;
    pr63_we_d = 1'b0;
    pr63_d    = 1'b0;
    rotate    = 1'b0;
    target_d  = target_q;
    link_d    = link_q;
    lc_d      = LC_WR_I ? LC_WDATA_I : lc_q;
    ec_d      = EC_WR_I ? EC_WDATA_I : ec_q;
    rrb_gr_d  = rrb_gr_q;
    rrb_fr_d  = rrb_fr_q;
    rrb_pr_d  = rrb_pr_q;
    sor_d     = sor_q;
    if (BR_VALID_I) begin
      if (is_loop && !slot_ok) begin
        illegal_d = 1'b1;
      end else begin
        unique case (kind)
          brr_pkg::K_COND: begin
            taken_d = qp;
          end
          brr_pkg::K_CALL: begin
            taken_d   = qp;
            link_we_d = qp;
            call_d    = qp;
            if (qp) begin
              link_d   = BUNDLE_IP_I + brr_pkg::BUNDLE_BYTES;
              rrb_gr_d = '0;
              rrb_fr_d = '0;
              rrb_pr_d = '0;
            end
          end
          brr_pkg::K_RET: begin
            taken_d = qp;
            ret_d   = qp;
          end
          brr_pkg::K_CLOOP: begin
            if (lc_q != '0) begin
              taken_d = 1'b1;
              lc_d    = lc_q - LC_W'(1);
            end
          end
          brr_pkg::K_CTOP: begin
            pr63_we_d = 1'b1;
            if (lc_q != '0) begin
              taken_d = 1'b1;
              lc_d    = lc_q - LC_W'(1);
              rotate  = 1'b1;
              pr63_d  = 1'b1;
            end else if (ec_q != '0) begin
              taken_d = (ec_q != EC_W'(1));
              ec_d    = ec_q - EC_W'(1);
              rotate  = 1'b1;
            end
          end
          brr_pkg::K_WTOP: begin
            pr63_we_d = 1'b1;
            if (qp) begin
              taken_d = 1'b1;
              rotate  = 1'b1;
            end else if (ec_q != '0) begin
              taken_d = (ec_q != EC_W'(1));
              ec_d    = ec_q - EC_W'(1);
              rotate  = 1'b1;
            end
          end
          brr_pkg::K_CLRRRB: begin
            rrb_gr_d = '0;
            rrb_fr_d = '0;
            rrb_pr_d = '0;
          end
          brr_pkg::K_CLRRRB_PR: begin
            rrb_pr_d = '0;
          end
          brr_pkg::K_ALLOC: begin
            // Size must be a multiple of 8 and fit above register 32
            if ((ALLOC_SOR_I[2:0] != brr_pkg::SOR_GRAIN) || (ALLOC_SOR_I > brr_pkg::GR_ROT_MAX)) begin
              illegal_d = 1'b1;
            end else begin
              sor_d = ALLOC_SOR_I;
            end
          end
          default: illegal_d = 1'b1;
        endcase
      end
    end
    // Decrement in unison, general base only when its size is nonzero; wrap from zero to the top of each region
    if (rotate) begin
      rrb_fr_d = (rrb_fr_q == '0) ? brr_pkg::FR_ROT_SIZE - 7'h01 : rrb_fr_q - 7'h01;
      rrb_pr_d = (rrb_pr_q == '0) ? brr_pkg::PR_ROT_SIZE - 6'h01 : rrb_pr_q - 6'h01;
      if (sor_q != '0) begin
        rrb_gr_d = (rrb_gr_q == '0) ? sor_q - 7'h01 : rrb_gr_q - 7'h01;
      end
    end
    // Target register only moves on a taken branch
    if (taken_d) begin
      target_d = tgt;
    end
  end

  // Registers; no documented reset values, so zero is chosen
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      taken_q   <= 1'b0;
      target_q  <= '0;
      illegal_q <= 1'b0;
      link_we_q <= 1'b0;
      link_q    <= '0;
      call_q    <= 1'b0;
      ret_q     <= 1'b0;
      pr63_we_q <= 1'b0;
      pr63_q    <= 1'b0;
      lc_q      <= '0;
      ec_q      <= '0;
      rrb_gr_q  <= '0;
      rrb_fr_q  <= '0;
      rrb_pr_q  <= '0;
      sor_q     <= '0;
      gr_phys_q <= '0;
      fr_phys_q <= '0;
      pr_phys_q <= '0;
    end else begin
      taken_q   <= taken_d;
      target_q  <= target_d;
      illegal_q <= illegal_d;
      link_we_q <= link_we_d;
      link_q    <= link_d;
      call_q    <= call_d;
      ret_q     <= ret_d;
      pr63_we_q <= pr63_we_d;
      pr63_q    <= pr63_d;
      lc_q      <= lc_d;
      ec_q      <= ec_d;
      rrb_gr_q  <= rrb_gr_d;
      rrb_fr_q  <= rrb_fr_d;
      rrb_pr_q  <= rrb_pr_d;
      sor_q     <= sor_d;
      gr_phys_q <= gr_phys;
      fr_phys_q <= fr_phys;
      pr_phys_q <= pr_phys;
    end
  end

  // ---------------------------------------------------------------
  // Renamers; lookups use the bases held before this cycle's op
  // ---------------------------------------------------------------
  brr_rename #(.W(7), .BASE(brr_pkg::GR_ROT_BASE)) u_ren_gr (
    .num_i  (GR_NUM_I),
    .size_i (sor_q),
    .rrb_i  (rrb_gr_q),
    .phys_o (gr_phys)
  );
  brr_rename #(.W(7), .BASE(brr_pkg::FR_ROT_BASE)) u_ren_fr (
    .num_i  (FR_NUM_I),
    .size_i (brr_pkg::FR_ROT_SIZE),
    .rrb_i  (rrb_fr_q),
    .phys_o (fr_phys)
  );
  brr_rename #(.W(6), .BASE(brr_pkg::PR_ROT_BASE)) u_ren_pr (
    .num_i  (PR_NUM_I),
    .size_i (brr_pkg::PR_ROT_SIZE),
    .rrb_i  (rrb_pr_q),
    .phys_o (pr_phys)
  );

  // Outputs; taken doubles as squash of younger ops in the group
  assign TAKEN_O        = taken_q;
  assign TARGET_O       = target_q;
  assign ILLEGAL_OP_O   = illegal_q;
  assign LINK_WE_O      = link_we_q;
  assign LINK_DATA_O    = link_q;
  assign STACK_CALL_O   = call_q;
  assign STACK_RET_O    = ret_q;
  assign PR63_WE_O      = pr63_we_q;
  assign PR63_VALUE_O   = pr63_q;
  assign LOOP_COUNT_O   = lc_q;
  assign EPILOG_COUNT_O = ec_q;
  assign RRB_GR_O       = rrb_gr_q;
  assign RRB_FR_O       = rrb_fr_q;
  assign RRB_PR_O       = rrb_pr_q;
  assign ROT_SIZE_GR_O  = sor_q;
  assign GR_PHYS_O      = gr_phys_q;
  assign FR_PHYS_O      = fr_phys_q;
  assign PR_PHYS_O      = pr_phys_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  a_target_aligned: assert property (taken_q |-> TARGET_O[3:0] == 4'h0)
    else $error("taken target not bundle aligned");
  a_cond_taken: assert property (BR_VALID_I && kind == brr_pkg::K_COND |=> TAKEN_O == $past(qp))
    else $error("conditional jump direction wrong");
  a_iprel_target: assert property (BR_VALID_I && kind == brr_pkg::K_COND && BR_MODE_I == brr_pkg::M_IPREL && qp
    |=> TARGET_O == $past(BUNDLE_IP_I) + {{39{$past(DISP21_I[20])}}, $past(DISP21_I), 4'h0})
    else $error("ip-relative target wrong");
  a_pr0_uncond: assert property (BR_VALID_I && kind == brr_pkg::K_RET && QP_NUM_I == 6'h00
    |=> TAKEN_O && STACK_RET_O)
    else $error("predicate zero did not force taken");
  a_call_link: assert property (BR_VALID_I && kind == brr_pkg::K_CALL && qp
    |=> LINK_WE_O && STACK_CALL_O && LINK_DATA_O == $past(BUNDLE_IP_I) + 64'h10)
    else $error("call link write wrong");
  a_cloop_dec: assert property (BR_VALID_I && kind == brr_pkg::K_CLOOP && slot_ok && lc_q != '0
    |=> TAKEN_O && LOOP_COUNT_O == $past(lc_q) - LC_W'(1))
    else $error("counted loop did not decrement");
  a_loop_slot: assert property (BR_VALID_I && is_loop && !slot_ok && !LC_WR_I
    |=> ILLEGAL_OP_O && !TAKEN_O && $stable(RRB_FR_O) && $stable(LOOP_COUNT_O))
    else $error("loop branch outside slot 2 not faulted");
  a_clr_pr_only: assert property (BR_VALID_I && kind == brr_pkg::K_CLRRRB_PR && !LC_WR_I
    |=> RRB_PR_O == 6'h00 && $stable(RRB_FR_O) && $stable(RRB_GR_O))
    else $error("predicate base reset touched other bases");
  a_fr_wrap: assert property (rotate && rrb_fr_q == 7'h00 |=> RRB_FR_O == 7'h5F)
    else $error("float base did not wrap to 95");
  a_gr_norot: assert property (rotate && sor_q == 7'h00 |=> RRB_GR_O == 7'h00)
    else $error("general base rotated with zero size");
  a_ctop_kernel: assert property (BR_VALID_I && kind == brr_pkg::K_CTOP && slot_ok && lc_q != '0
    |=> TAKEN_O && PR63_WE_O && PR63_VALUE_O && LOOP_COUNT_O == $past(lc_q) - LC_W'(1))
    else $error("counted modulo kernel step wrong");
  a_ctop_epilog: assert property (BR_VALID_I && kind == brr_pkg::K_CTOP && slot_ok && lc_q == '0 && ec_q > 6'h01
    && !EC_WR_I |=> TAKEN_O && !PR63_VALUE_O && EPILOG_COUNT_O == $past(ec_q) - 6'h01)
    else $error("counted modulo epilog step wrong");
  a_notaken_hold: assert property (BR_VALID_I && kind == brr_pkg::K_COND && !qp
    |=> !TAKEN_O && $stable(TARGET_O) && $stable(RRB_PR_O))
    else $error("not-taken branch changed state");

  c_cloop_taken: cover property (BR_VALID_I && kind == brr_pkg::K_CLOOP && slot_ok ##1 TAKEN_O);
  c_ctop_epilog: cover property (BR_VALID_I && kind == brr_pkg::K_CTOP && lc_q == '0 && ec_q > 6'h01);
  c_wtop_rotate: cover property (BR_VALID_I && kind == brr_pkg::K_WTOP && rotate);
  c_call_taken:  cover property (BR_VALID_I && kind == brr_pkg::K_CALL && qp);
endmodule // brr_top

/* verif/brr_top_bench.sv */
// Self-checking bench for the branch resolve and register rotation top.
// Assumes brr_pkg is compiled first; drives all ports directly.
`timescale 1ns/1ps
module brr_top_bench;
  logic        MCLK_I, RESET_I, BR_VALID_I, QP_VALUE_I, LC_WR_I, EC_WR_I;
  logic [3:0]  BR_KIND_I;
  logic [1:0]  BR_MODE_I, BR_SLOT_I;
  logic [63:0] BUNDLE_IP_I, BREG_TARGET_I, LC_WDATA_I;
  logic [20:0] DISP21_I;
  logic [59:0] DISP60_I;
  logic [5:0]  QP_NUM_I, PR_NUM_I, EC_WDATA_I;
  logic [6:0]  ALLOC_SOR_I, GR_NUM_I, FR_NUM_I;
  logic        taken, illegal, link_we, st_call, st_ret, pr_we, pr_val;
  logic [63:0] target, link, lc;
  logic [5:0]  ec, rrb_pr, pr_phys;
  logic [6:0]  rrb_gr, rrb_fr, sz_gr, gr_phys, fr_phys;
  int          n_errors = 0, checked = 0, cyc = 0;

  brr_top i_brr_top (.MCLK_I(MCLK_I), .RESET_I(RESET_I), .BR_VALID_I(BR_VALID_I), .BR_KIND_I(BR_KIND_I),
    .BR_MODE_I(BR_MODE_I), .BR_SLOT_I(BR_SLOT_I), .BUNDLE_IP_I(BUNDLE_IP_I), .DISP21_I(DISP21_I),
    .DISP60_I(DISP60_I), .BREG_TARGET_I(BREG_TARGET_I), .QP_NUM_I(QP_NUM_I), .QP_VALUE_I(QP_VALUE_I),
    .ALLOC_SOR_I(ALLOC_SOR_I), .LC_WR_I(LC_WR_I), .LC_WDATA_I(LC_WDATA_I), .EC_WR_I(EC_WR_I),
    .EC_WDATA_I(EC_WDATA_I), .GR_NUM_I(GR_NUM_I), .FR_NUM_I(FR_NUM_I), .PR_NUM_I(PR_NUM_I),
    .TAKEN_O(taken), .TARGET_O(target), .ILLEGAL_OP_O(illegal), .LINK_WE_O(link_we), .LINK_DATA_O(link),
    .STACK_CALL_O(st_call), .STACK_RET_O(st_ret), .PR63_WE_O(pr_we), .PR63_VALUE_O(pr_val),
    .LOOP_COUNT_O(lc), .EPILOG_COUNT_O(ec), .RRB_GR_O(rrb_gr), .RRB_FR_O(rrb_fr), .RRB_PR_O(rrb_pr),
    .ROT_SIZE_GR_O(sz_gr), .GR_PHYS_O(gr_phys), .FR_PHYS_O(fr_phys), .PR_PHYS_O(pr_phys));

  // ---------------------------------------------------------------
  // Clock, timeout and verdict
  // ---------------------------------------------------------------
  initial begin
    MCLK_I = 1'b0;
    forever #2.5 MCLK_I = ~MCLK_I;
  end
  // Whole run needs well under 200 cycles; ceiling leaves ample slack
  always @(posedge MCLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Compare tasks and access tasks
  // ---------------------------------------------------------------
  task automatic chk_val(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // One op in one cycle; pulses are looked at in the cycle they stand
  task automatic op(input logic [3:0] k, input logic [1:0] m, input logic [1:0] s, input logic qv);
    @(posedge MCLK_I);
    BR_VALID_I <= 1'b1;
    BR_KIND_I  <= k;
    BR_MODE_I  <= m;
    BR_SLOT_I  <= s;
    QP_VALUE_I <= qv;
    @(posedge MCLK_I);
    BR_VALID_I <= 1'b0;
    #1;
  endtask
  task automatic set_counts(input logic [63:0] l, input logic [5:0] e);
    @(posedge MCLK_I);
    {LC_WR_I, EC_WR_I, LC_WDATA_I, EC_WDATA_I} <= {1'b1, 1'b1, l, e};
    @(posedge MCLK_I);
    {LC_WR_I, EC_WR_I} <= 2'h0;
    #1;
  endtask
  // Loop step: expected taken, PR63 value and all three bases
  task automatic loop_step(input logic [3:0] k, input logic qv, input logic tk, input logic pv,
                           input logic [6:0] g, input logic [6:0] f, input logic [5:0] p);
    op(k, 2'h0, 2'h2, qv);
    chk_bit("taken", tk, taken);
    chk_bit("pr63_we", 1'b1, pr_we);
    chk_bit("pr63_value", pv, pr_val);
    chk_val("rrb", {g, f, p}, {rrb_gr, rrb_fr, rrb_pr});
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {RESET_I, BR_VALID_I, QP_VALUE_I, LC_WR_I, EC_WR_I} = 5'h10;
    {BR_KIND_I, BR_MODE_I, BR_SLOT_I} = 8'h00;
    {BUNDLE_IP_I, BREG_TARGET_I, LC_WDATA_I} = {64'h0000_0000_0000_1000, 64'h0000_0000_00AB_CD50, 64'h0};
    {DISP21_I, DISP60_I} = {21'h1FFFFE, 60'hF00_0000_0000_0001};
    {QP_NUM_I, PR_NUM_I, EC_WDATA_I} = {6'h05, 6'h10, 6'h00};
    {ALLOC_SOR_I, GR_NUM_I, FR_NUM_I} = {7'h10, 7'h20, 7'h20};
    repeat (10) @(posedge MCLK_I);
    RESET_I <= 1'b0;
    #1;
    chk_val("rrb_reset", 64'h0, {rrb_gr, rrb_fr, rrb_pr, lc[7:0]});
    // Target modes: negative short displacement, long one with high bits set, register
    op(brr_pkg::K_COND, 2'h0, 2'h0, 1'b1);
    chk_bit("taken", 1'b1, taken);
    chk_val("target", BUNDLE_IP_I + ({{43{DISP21_I[20]}}, DISP21_I} << 4), target);
    op(brr_pkg::K_COND, 2'h2, 2'h0, 1'b0);
    chk_bit("taken", 1'b0, taken);
    chk_val("target", 64'h0000_0000_0000_0FE0, target);
    op(brr_pkg::K_COND, 2'h1, 2'h1, 1'b1);
    chk_val("target", BUNDLE_IP_I + {DISP60_I, 4'h0}, target);
    @(posedge MCLK_I) QP_NUM_I <= 6'h00;
    op(brr_pkg::K_COND, 2'h2, 2'h0, 1'b0);
    chk_val("target", BREG_TARGET_I, target);
    // Call then return, both unconditional through predicate zero
    op(brr_pkg::K_CALL, 2'h0, 2'h0, 1'b0);
    chk_val("link", 64'h0000_0000_0000_1010, link);
    chk_bit("link_we", 1'b1, link_we);
    chk_bit("stack_call", 1'b1, st_call);
    op(brr_pkg::K_RET, 2'h2, 2'h0, 1'b0);
    chk_val("target", BREG_TARGET_I, target);
    chk_bit("stack_ret", 1'b1, st_ret);
    @(posedge MCLK_I) QP_NUM_I <= 6'h05;
    // Simple counted loop: wrong slot, nonzero, zero
    set_counts(64'h2, 6'h2);
    op(brr_pkg::K_CLOOP, 2'h0, 2'h1, 1'b1);
    chk_bit("illegal", 1'b1, illegal);
    op(brr_pkg::K_CTOP, 2'h0, 2'h1, 1'b1);
    chk_bit("illegal", 1'b1, illegal);
    chk_val("illegal_lc", 64'h2, lc);
    chk_bit("illegal_pr63_we", 1'b0, pr_we);
    op(brr_pkg::K_CLOOP, 2'h0, 2'h2, 1'b1);
    chk_bit("taken", 1'b1, taken);
    chk_val("taken_lc", 64'h1, lc);
    set_counts(64'h0, 6'h2);
    op(brr_pkg::K_CLOOP, 2'h0, 2'h2, 1'b1);
    chk_bit("taken", 1'b0, taken);
    chk_val("fall_lc", 64'h0, lc);
    // Rotating sizes: legal while all bases are zero, then not a multiple of 8
    chk_val("rrb_before_alloc", 64'h0, {rrb_gr, rrb_fr, rrb_pr});
    op(brr_pkg::K_ALLOC, 2'h0, 2'h0, 1'b1);
    @(posedge MCLK_I) ALLOC_SOR_I <= 7'h0C;
    op(brr_pkg::K_ALLOC, 2'h0, 2'h0, 1'b1);
    chk_bit("illegal", 1'b1, illegal);
    chk_val("size_gr", 64'h10, {57'h0, sz_gr});
    // Modulo loop through kernel, epilog, exit, idle exit and while kernel
    set_counts(64'h1, 6'h2);
    loop_step(brr_pkg::K_CTOP, 1'b0, 1'b1, 1'b1, 7'h0F, 7'h5F, 6'h2F);
    loop_step(brr_pkg::K_CTOP, 1'b0, 1'b1, 1'b0, 7'h0E, 7'h5E, 6'h2E);
    loop_step(brr_pkg::K_CTOP, 1'b0, 1'b0, 1'b0, 7'h0D, 7'h5D, 6'h2D);
    loop_step(brr_pkg::K_CTOP, 1'b0, 1'b0, 1'b0, 7'h0D, 7'h5D, 6'h2D);
    loop_step(brr_pkg::K_WTOP, 1'b1, 1'b1, 1'b0, 7'h0C, 7'h5C, 6'h2C);
    chk_val("counts", 64'h0, lc + {58'h0, ec});
    // Renamed numbers trail the bases by one edge, so let one edge pass
    @(posedge MCLK_I) GR_NUM_I <= 7'h30;
    #1;
    chk_val("gr_phys", 64'h2C, {57'h0, gr_phys});
    chk_val("fr_phys", 64'h7C, {57'h0, fr_phys});
    chk_val("pr_phys", 64'h3C, {58'h0, pr_phys});
    op(brr_pkg::K_CLRRRB_PR, 2'h0, 2'h0, 1'b1);
    chk_val("rrb", {7'h0C, 7'h5C, 6'h00}, {rrb_gr, rrb_fr, rrb_pr});
    chk_val("gr_outside", 64'h30, {57'h0, gr_phys});
    op(brr_pkg::K_CLRRRB, 2'h0, 2'h0, 1'b1);
    chk_val("rrb", 64'h0, {rrb_gr, rrb_fr, rrb_pr});
    // Zero general size: only float and predicate bases move; while epilog step
    @(posedge MCLK_I) ALLOC_SOR_I <= 7'h00;
    op(brr_pkg::K_ALLOC, 2'h0, 2'h0, 1'b1);
    set_counts(64'h0, 6'h2);
    loop_step(brr_pkg::K_WTOP, 1'b0, 1'b1, 1'b0, 7'h00, 7'h5F, 6'h2F);
    chk_val("ec", 64'h1, {58'h0, ec});
    // Unknown op kind faults and leaves control flow alone
    op(4'hF, 2'h0, 2'h0, 1'b1);
    chk_bit("illegal", 1'b1, illegal);
    chk_bit("taken", 1'b0, taken);
    complete_run();
  end
endmodule // brr_top_bench
